// *** design/tmc_top.sv ***
// four compare units sharing one 16-bit timer, registers on an apb slave
// assumes a synchronous apb master on sys_clk_i and a one-cycle timer clock tick input
//
// What this block does
// - each unit compares its 16-bit value with the timer count every cycle.
// - match actions are toggle, set, clear, special event trigger, interrupt only.
// - match flag sets in the same cycle as the output latch action, one cycle before the pin follows.
// - writing zero to a unit control register drives its output latch low.
// - mode 1010 flags the match only and leaves the pin alone.
// - unit two's pin can be moved to an alternative pin by the remap register.
// - compare behaviour is the same in all four units.
// - control register holds bridge config 7:6 (units one and two only), duty low 5:4, mode 3:0.
// - unimplemented bits of control, flag and enable registers read zero.
// - timer count is reachable as separate low and high byte registers.
// - mode 1011 resets the timer, starts a conversion, leaves the pin alone.
// - trigger fires at once; timer clears at next timer tick if still matching.
// - a trigger-caused timer clear never sets the timer overflow flag.
// - compare needs the system clock; nothing runs while it is stopped.
`include "tmc_consts.svh"
module tmc_top
    import tmc_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        tmr_tick_i,
    output logic [3:0]       unit_pin_o,
    output logic [3:0]       unit_pin_own_o,
    output logic             unit2_alt_pin_o,
    output logic             unit2_alt_own_o,
    output logic             event_trigger_o,
    output logic             conv_start_o,
    input  wire logic        conv_enable_i
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    tmc_apb_req_s req;
    tmc_ctrl_s    ctrl_q [4];
    logic [7:0]   cmp_lo_q [4];
    logic [7:0]   cmp_hi_q [4];
    logic [15:0]  tmr_q;
    logic [7:0]   flags1_q, flags2_q, flags3_q;
    logic [7:0]   enable1_q, enable2_q, enable3_q;
    logic [7:0]   remap0_q, remap1_q, tmr_ctrl_q;
    logic [3:0]   latch_q, match_prev_q, sev_pend_q;
    logic [3:0]   match, fire, owns_pin, is_cmp, sev_fire;
    logic         wr_en, access;
    logic [7:0]   wbyte;
    logic [31:0]  rdata_d;
    logic         unmapped;
    logic         sev_clear;
    logic [3:0]   cmp_wr, cmp_hit, unit_hit;

    assign req      = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};
    assign access   = req.psel && req.penable && !pready_o;
    assign wr_en    = access && req.pwrite;
    assign wbyte    = req.pwdata[7:0];

    // ----------------------------------------------------------------
    // match detection per unit
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `TMC_UNITS; g++)
        begin : g_unit
            logic [3:0] m;
            assign m           = ctrl_q[g].match_mode_field;
            assign match[g]    = (tmr_q == {cmp_hi_q[g], cmp_lo_q[g]});
            assign is_cmp[g]   = (m == `TMC_MODE_TOGGLE) || (m == `TMC_MODE_SET) ||
                                 (m == `TMC_MODE_CLEAR) || (m == `TMC_MODE_SWI) ||
                                 (m == `TMC_MODE_SEV);
            assign owns_pin[g] = (m == `TMC_MODE_TOGGLE) || (m == `TMC_MODE_SET) ||
                                 (m == `TMC_MODE_CLEAR);
            assign fire[g]     = is_cmp[g] && match[g] && !match_prev_q[g];
            assign sev_fire[g] = fire[g] && (m == `TMC_MODE_SEV);
            assign cmp_hit[g]  = (req.paddr == `TMC_OFS_CMP_BASE + 8'(8 * g)) ||
                                 (req.paddr == `TMC_OFS_CMP_BASE + 8'(8 * g + 4));
            assign cmp_wr[g]   = wr_en && cmp_hit[g];
            assign unit_hit[g] = (req.paddr == `TMC_OFS_UNIT_CTRL0 + 8'(4 * g)) || cmp_hit[g];
        end
    endgenerate

    // a pending clear survives only while the unit still matches
    assign sev_clear = |(sev_pend_q & match & is_cmp);

    // ----------------------------------------------------------------
    // unit control and compare value registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q   <= '{default: `TMC_REG_RESET};
            cmp_lo_q <= '{default: `TMC_REG_RESET};
            cmp_hi_q <= '{default: `TMC_REG_RESET};
        end
        else
        begin
            for (int i = 0; i < `TMC_UNITS; i++)
            begin
                if (wr_en && req.paddr == `TMC_OFS_UNIT_CTRL0 + 8'(4 * i))
                    ctrl_q[i] <= wbyte & ((i < 2) ? `TMC_CTRL_MASK_ENH : `TMC_CTRL_MASK_STD);
                if (wr_en && req.paddr == `TMC_OFS_CMP_BASE + 8'(8 * i))
                    cmp_lo_q[i] <= wbyte;
                if (wr_en && req.paddr == `TMC_OFS_CMP_BASE + 8'(8 * i + 4))
                    cmp_hi_q[i] <= wbyte;
            end
        end
    end

    // ----------------------------------------------------------------
    // output latches and match history
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            latch_q      <= 4'h0;
            match_prev_q <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < `TMC_UNITS; i++)
            begin
                match_prev_q[i] <= match[i];
                if (wr_en && req.paddr == `TMC_OFS_UNIT_CTRL0 + 8'(4 * i) && wbyte == `TMC_REG_RESET)
                    latch_q[i] <= 1'b0;
                else if (fire[i])
                    case (ctrl_q[i].match_mode_field)
                        `TMC_MODE_TOGGLE: latch_q[i] <= !latch_q[i];
                        `TMC_MODE_SET:    latch_q[i] <= 1'b1;
                        `TMC_MODE_CLEAR:  latch_q[i] <= 1'b0;
                        default:          latch_q[i] <= latch_q[i];
                    endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drive, remap and special event outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            unit_pin_o      <= 4'h0;
            unit_pin_own_o  <= 4'h0;
            unit2_alt_pin_o <= 1'b0;
            unit2_alt_own_o <= 1'b0;
            event_trigger_o <= 1'b0;
            conv_start_o    <= 1'b0;
        end
        else
        begin
            // remapped unit two leaves its default pin
            unit_pin_o         <= latch_q & ~{2'b00, remap1_q[`TMC_POS_U2_REMAP], 1'b0};
            unit_pin_own_o     <= owns_pin & ~{2'b00, remap1_q[`TMC_POS_U2_REMAP], 1'b0};
            unit2_alt_pin_o    <= remap1_q[`TMC_POS_U2_REMAP] && latch_q[1];
            unit2_alt_own_o    <= remap1_q[`TMC_POS_U2_REMAP] && owns_pin[1];
            event_trigger_o    <= |sev_fire;
            conv_start_o       <= |sev_fire && conv_enable_i;
        end
    end

    // ----------------------------------------------------------------
    // shared timer with trigger reset
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            sev_pend_q <= 4'h0;
        else
            for (int i = 0; i < `TMC_UNITS; i++)
                if (sev_fire[i])
                    sev_pend_q[i] <= 1'b1;
                else if (tmr_tick_i || !match[i] || cmp_wr[i])
                    sev_pend_q[i] <= 1'b0;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            tmr_q <= 16'h0000;
        else if (wr_en && req.paddr == `TMC_OFS_TMR_LOW)
            tmr_q[7:0] <= wbyte;
        else if (wr_en && req.paddr == `TMC_OFS_TMR_HIGH)
            tmr_q[15:8] <= wbyte;
        else if (tmr_tick_i && sev_clear)
            tmr_q <= 16'h0000;
        else if (tmr_tick_i && tmr_ctrl_q[`TMC_POS_TMR_RUN])
            tmr_q <= tmr_q + `TMC_TMR_ONE;
    end

    // ----------------------------------------------------------------
    // flag registers, hardware set wins over software clear
    // ----------------------------------------------------------------
    logic ovf_set;
    assign ovf_set = tmr_tick_i && !sev_clear && tmr_ctrl_q[`TMC_POS_TMR_RUN] && tmr_q == `TMC_TMR_MAX
                     && !(wr_en && (req.paddr == `TMC_OFS_TMR_LOW || req.paddr == `TMC_OFS_TMR_HIGH));

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            flags1_q <= `TMC_REG_RESET;
            flags2_q <= `TMC_REG_RESET;
            flags3_q <= `TMC_REG_RESET;
        end
        else
        begin
            flags1_q <= ((wr_en && req.paddr == `TMC_OFS_FLAGS1) ? (wbyte & `TMC_FLAGS1_MASK) : flags1_q)
                        | (8'(fire[0]) << `TMC_POS_U1_FLAG) | (8'(ovf_set) << `TMC_POS_OVF);
            flags2_q <= ((wr_en && req.paddr == `TMC_OFS_FLAGS2) ? (wbyte & `TMC_FLAGS2_MASK) : flags2_q)
                        | (8'(fire[1]) << `TMC_POS_U2_FLAG);
            flags3_q <= ((wr_en && req.paddr == `TMC_OFS_FLAGS3) ? (wbyte & `TMC_FLAGS3_MASK) : flags3_q)
                        | (8'(fire[2]) << `TMC_POS_U3_FLAG) | (8'(fire[3]) << `TMC_POS_U4_FLAG);
        end
    end

    // ----------------------------------------------------------------
    // enable, remap and timer control registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            enable1_q  <= `TMC_REG_RESET;
            enable2_q  <= `TMC_REG_RESET;
            enable3_q  <= `TMC_REG_RESET;
            remap0_q   <= `TMC_REG_RESET;
            remap1_q   <= `TMC_REG_RESET;
            tmr_ctrl_q <= `TMC_REG_RESET;
        end
        else if (wr_en)
        begin
            case (req.paddr)
                `TMC_OFS_ENABLE1:  enable1_q  <= wbyte & `TMC_FLAGS1_MASK;
                `TMC_OFS_ENABLE2:  enable2_q  <= wbyte & `TMC_FLAGS2_MASK;
                `TMC_OFS_ENABLE3:  enable3_q  <= wbyte & `TMC_FLAGS3_MASK;
                `TMC_OFS_REMAP0:   remap0_q   <= wbyte;
                `TMC_OFS_REMAP1:   remap1_q   <= wbyte & `TMC_REMAP1_MASK;
                `TMC_OFS_TMR_CTRL: tmr_ctrl_q <= wbyte & `TMC_TMR_CTRL_MASK;
                default:           tmr_ctrl_q <= tmr_ctrl_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // apb read mux and answer, one wait state
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_d  = 32'h0000_0000;
        unmapped = 1'b0;
        case (req.paddr)
            `TMC_OFS_TMR_LOW:  rdata_d[7:0] = tmr_q[7:0];
            `TMC_OFS_TMR_HIGH: rdata_d[7:0] = tmr_q[15:8];
            `TMC_OFS_FLAGS1:   rdata_d[7:0] = flags1_q;
            `TMC_OFS_FLAGS2:   rdata_d[7:0] = flags2_q;
            `TMC_OFS_FLAGS3:   rdata_d[7:0] = flags3_q;
            `TMC_OFS_ENABLE1:  rdata_d[7:0] = enable1_q;
            `TMC_OFS_ENABLE2:  rdata_d[7:0] = enable2_q;
            `TMC_OFS_ENABLE3:  rdata_d[7:0] = enable3_q;
            `TMC_OFS_REMAP0:   rdata_d[7:0] = remap0_q;
            `TMC_OFS_REMAP1:   rdata_d[7:0] = remap1_q;
            `TMC_OFS_TMR_CTRL: rdata_d[7:0] = tmr_ctrl_q;
            default:           unmapped = 1'b1;
        endcase
        if (|unit_hit)
            unmapped = 1'b0;
        for (int i = 0; i < `TMC_UNITS; i++)
        begin
            if (req.paddr == `TMC_OFS_UNIT_CTRL0 + 8'(4 * i))
                rdata_d = {24'h00_0000, ctrl_q[i]};
            if (req.paddr == `TMC_OFS_CMP_BASE + 8'(8 * i))
                rdata_d = {24'h00_0000, cmp_lo_q[i]};
            if (req.paddr == `TMC_OFS_CMP_BASE + 8'(8 * i + 4))
                rdata_d = {24'h00_0000, cmp_hi_q[i]};
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
        else
        begin
            pready_o  <= access;
            pslverr_o <= access && unmapped;
            prdata_o  <= (access && !req.pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_flag_on_fire;
        @(posedge sys_clk_i) disable iff (rst_i) fire[0] |=> flags1_q[`TMC_POS_U1_FLAG];
    endproperty
    a_flag_on_fire: assert property (p_flag_on_fire) else $error("match flag not set");
    property p_flag_sticky;
        @(posedge sys_clk_i) disable iff (rst_i)
            flags3_q[`TMC_POS_U4_FLAG] && !(wr_en && req.paddr == `TMC_OFS_FLAGS3) |=> flags3_q[`TMC_POS_U4_FLAG];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("match flag dropped");
    property p_fire_once;
        @(posedge sys_clk_i) disable iff (rst_i) fire[2] |=> !fire[2];
    endproperty
    a_fire_once: assert property (p_fire_once) else $error("match fired twice");
    property p_toggle;
        @(posedge sys_clk_i) disable iff (rst_i)
            fire[0] && ctrl_q[0].match_mode_field == `TMC_MODE_TOGGLE && !wr_en |=> latch_q[0] != $past(latch_q[0]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");
    property p_zero_ctrl;
        @(posedge sys_clk_i) disable iff (rst_i)
            wr_en && req.paddr == `TMC_OFS_UNIT_CTRL0 && wbyte == `TMC_REG_RESET |=> ##1 !unit_pin_o[0];
    endproperty
    a_zero_ctrl: assert property (p_zero_ctrl) else $error("latch not cleared");
    property p_swi_no_pin;
        @(posedge sys_clk_i) disable iff (rst_i)
            ctrl_q[2].match_mode_field == `TMC_MODE_SWI |=> !unit_pin_own_o[2];
    endproperty
    a_swi_no_pin: assert property (p_swi_no_pin) else $error("pin owned in interrupt mode");
    property p_sev_pulse;
        @(posedge sys_clk_i) disable iff (rst_i)
            fire[3] && ctrl_q[3].match_mode_field == `TMC_MODE_SEV |=> event_trigger_o;
    endproperty
    a_sev_pulse: assert property (p_sev_pulse) else $error("trigger late");
    property p_sev_no_ovf;
        @(posedge sys_clk_i) disable iff (rst_i)
            tmr_tick_i && sev_clear && !flags1_q[`TMC_POS_OVF] && !wr_en |=> !flags1_q[`TMC_POS_OVF];
    endproperty
    a_sev_no_ovf: assert property (p_sev_no_ovf) else $error("overflow set by trigger");
    property p_std_bits;
        @(posedge sys_clk_i) disable iff (rst_i) ctrl_q[2].bridge_output_config == 2'b00;
    endproperty
    a_std_bits: assert property (p_std_bits) else $error("unimplemented bits set");
    property p_apb_answer;
        @(posedge sys_clk_i) disable iff (rst_i) psel_i && penable_i && !pready_o |=> pready_o;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer missing");

endmodule

// *** pkg/tmc_consts.svh ***
// register offsets, field positions and mode codes of the timer match compare unit
// assumes inclusion by bare name from the package and the design module
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define TMC_ADDR_W          8
`define TMC_OFS_UNIT_CTRL0  8'h00
`define TMC_OFS_CMP_BASE    8'h10
`define TMC_OFS_TMR_LOW     8'h30
`define TMC_OFS_TMR_HIGH    8'h34
`define TMC_OFS_FLAGS1      8'h38
`define TMC_OFS_FLAGS2      8'h3C
`define TMC_OFS_FLAGS3      8'h40
`define TMC_OFS_ENABLE1     8'h44
`define TMC_OFS_ENABLE2     8'h48
`define TMC_OFS_ENABLE3     8'h4C
`define TMC_OFS_REMAP1      8'h50
`define TMC_OFS_REMAP0      8'h54
`define TMC_OFS_TMR_CTRL    8'h58

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define TMC_UNITS           4
`define TMC_CTRL_MASK_ENH   8'hFF
`define TMC_CTRL_MASK_STD   8'h3F
`define TMC_FLAGS1_MASK     8'hFF
`define TMC_FLAGS2_MASK     8'hF9
`define TMC_FLAGS3_MASK     8'h3A
`define TMC_REMAP1_MASK     8'h3F
`define TMC_POS_OVF         0
`define TMC_POS_U1_FLAG     2
`define TMC_POS_U2_FLAG     0
`define TMC_POS_U3_FLAG     4
`define TMC_POS_U4_FLAG     5
`define TMC_POS_U2_REMAP    0
`define TMC_POS_TMR_RUN     0
`define TMC_TMR_CTRL_MASK   8'h01
`define TMC_REG_RESET       8'h00
`define TMC_TMR_MAX         16'hFFFF
`define TMC_TMR_ONE         16'h0001

// ----------------------------------------------------------------
// match mode codes
// ----------------------------------------------------------------
`define TMC_MODE_OFF        4'h0
`define TMC_MODE_TOGGLE     4'h2
`define TMC_MODE_SET        4'h8
`define TMC_MODE_CLEAR      4'h9
`define TMC_MODE_SWI        4'hA
`define TMC_MODE_SEV        4'hB

`endif

// *** pkg/tmc_pkg.sv ***
// types shared by the timer match compare unit
// assumes tmc_consts.svh on the include path
package tmc_pkg;
    `include "tmc_consts.svh"

    typedef struct packed {
        logic [1:0] bridge_output_config;
        logic [1:0] pwm_duty_low_bits;
        logic [3:0] match_mode_field;
    } tmc_ctrl_s;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tmc_apb_req_s;
endpackage

// *** verification/timer_match_compare_unit_tb_top.sv ***
// self-checking bench of the timer match compare unit
// assumes tmc_pkg compiled first and tmc_consts.svh on the include path
`include "tmc_consts.svh"
module timer_match_compare_unit_tb_top
    import tmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic        tmr_tick_i = 1'b0;
    logic        conv_enable_i = 1'b1;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, unit2_alt_pin_o, unit2_alt_own_o, event_trigger_o, conv_start_o;
    logic [3:0]  unit_pin_o, unit_pin_own_o;
    logic [4:0]  pad;
    logic [31:0] rdat;
    logic        rerr;
    logic        pin_m [4] = '{default: 1'b0};
    int          num_errors = 0, cmp_count = 0, ev_cnt = 0, cv_cnt = 0;
    logic [7:0]  fofs [4] = '{`TMC_OFS_FLAGS1, `TMC_OFS_FLAGS2, `TMC_OFS_FLAGS3, `TMC_OFS_FLAGS3};
    int          fbit [4] = '{`TMC_POS_U1_FLAG, `TMC_POS_U2_FLAG, `TMC_POS_U3_FLAG, `TMC_POS_U4_FLAG};
    int          mu [10] = '{0, 0, 0, 1, 1, 2, 2, 2, 3, 3};
    logic [3:0]  mm [10] = '{`TMC_MODE_SET, `TMC_MODE_TOGGLE, `TMC_MODE_TOGGLE, `TMC_MODE_CLEAR, `TMC_MODE_SET,
                             `TMC_MODE_TOGGLE, `TMC_MODE_SWI, `TMC_MODE_SEV, `TMC_MODE_SET, `TMC_MODE_SEV};
    logic [7:0]  ra [8] = '{8'h04, 8'h08, 8'h0C, `TMC_OFS_FLAGS2, `TMC_OFS_FLAGS3, `TMC_OFS_ENABLE2,
                            `TMC_OFS_ENABLE3, `TMC_OFS_REMAP1};
    logic [7:0]  rm [8] = '{8'hFF, 8'h3F, 8'h3F, 8'hF9, 8'h3A, 8'hF9, 8'h3A, 8'h3F};

    tmc_top DUT (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .tmr_tick_i, .unit_pin_o, .unit_pin_own_o, .unit2_alt_pin_o,
        .unit2_alt_own_o, .event_trigger_o, .conv_start_o, .conv_enable_i);
    tmc_pin_load LOAD (.unit_pin_i(unit_pin_o), .unit_own_i(unit_pin_own_o), .alt_pin_i(unit2_alt_pin_o),
        .alt_own_i(unit2_alt_own_o), .dir_is_out_i(4'hF), .pad_o(pad));

    always #5 sys_clk_i = ~sys_clk_i;

    always @(posedge sys_clk_i)
    begin
        if (event_trigger_o === 1'b1)
            ev_cnt++;
        if (conv_start_o === 1'b1)
            cv_cnt++;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 16);
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 16)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic do_match(input int u, input logic [3:0] m);
        tmc_ctrl_s  c;
        logic       own;
        int         ev0, cv0;
        logic [7:0] v;
        c = '{2'b00, 2'b01, m};
        own = (m == `TMC_MODE_TOGGLE) || (m == `TMC_MODE_SET) || (m == `TMC_MODE_CLEAR);
        v = 8'h10 + 8'(u);
        wr(`TMC_OFS_TMR_LOW, 32'h0000_0000);
        wr(`TMC_OFS_CMP_BASE + 8'(8 * u), {24'h00_0000, v});
        wr(`TMC_OFS_CMP_BASE + 8'(8 * u + 4), 32'h0000_0000);
        wr(8'(4 * u), {24'h00_0000, c});
        wr(fofs[u], 32'h0000_0000);
        ev0 = ev_cnt;
        cv0 = cv_cnt;
        wr(`TMC_OFS_TMR_LOW, {24'h00_0000, v});
        repeat (6) @(posedge sys_clk_i);
        if (m == `TMC_MODE_TOGGLE)
            pin_m[u] = ~pin_m[u];
        if (m == `TMC_MODE_SET)
            pin_m[u] = 1'b1;
        if (m == `TMC_MODE_CLEAR)
            pin_m[u] = 1'b0;
        chk(unit_pin_o[u], pin_m[u]);
        chk(unit_pin_own_o[u], own);
        chk(pad[u], pin_m[u] & own);
        chk(ev_cnt - ev0, m == `TMC_MODE_SEV);
        chk(cv_cnt - cv0, (m == `TMC_MODE_SEV) && conv_enable_i);
        rd(fofs[u]);
        chk(rdat[fbit[u]], 1'b1);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic check_regs();
        for (int i = 0; i < 8; i++)
        begin
            rd(ra[i]);
            chk(rdat, 32'h0000_0000);
            wr(ra[i], 32'h0000_00FF);
            rd(ra[i]);
            chk(rdat, {24'h00_0000, rm[i]});
            wr(ra[i], 32'h0000_0000);
        end
        rd(8'hFC);
        chk(rdat, 32'h0000_0000);
        chk(rerr, 1'b1);
        wr(`TMC_OFS_TMR_LOW, 32'h0000_0034);
        wr(`TMC_OFS_TMR_HIGH, 32'h0000_0012);
        rd(`TMC_OFS_TMR_LOW);
        chk(rdat, 32'h0000_0034);
        rd(`TMC_OFS_TMR_HIGH);
        chk(rdat, 32'h0000_0012);
        wr(`TMC_OFS_TMR_HIGH, 32'h0000_0000);
    endtask

    task automatic check_matches();
        for (int i = 0; i < 10; i++)
        begin
            conv_enable_i <= (i != 7);
            do_match(mu[i], mm[i]);
        end
    endtask

    task automatic check_trigger_clear();
        rd(`TMC_OFS_TMR_LOW);
        chk(rdat, 32'h0000_0013);
        wr(`TMC_OFS_TMR_CTRL, 32'h0000_0001);
        @(posedge sys_clk_i);
        tmr_tick_i <= 1'b1;
        @(posedge sys_clk_i);
        tmr_tick_i <= 1'b0;
        rd(`TMC_OFS_TMR_LOW);
        chk(rdat, 32'h0000_0000);
        rd(`TMC_OFS_FLAGS1);
        chk(rdat[`TMC_POS_OVF], 1'b0);
        wr(`TMC_OFS_TMR_CTRL, 32'h0000_0000);
    endtask

    task automatic check_remap_and_zero();
        wr(`TMC_OFS_REMAP1, 32'h0000_0001);
        repeat (3) @(posedge sys_clk_i);
        chk({unit2_alt_pin_o, unit2_alt_own_o, unit_pin_o[1], unit_pin_own_o[1], pad[4]}, 5'b11001);
        wr(`TMC_OFS_REMAP1, 32'h0000_0000);
        wr(8'h00, 32'h0000_0000);
        repeat (3) @(posedge sys_clk_i);
        chk({unit_pin_o[0], unit_pin_own_o[0]}, 2'b00);
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        check_regs();
        check_matches();
        check_trigger_clear();
        check_remap_and_zero();
        report_and_stop();
    end
endmodule

// *** verification/tmc_pin_load.sv ***
// external circuitry on the compare pins and the alternate pin
// assumes each pad is pulled low whenever no unit drives it
module tmc_pin_load
    import tmc_pkg::*;
(
    input  wire logic [3:0] unit_pin_i,
    input  wire logic [3:0] unit_own_i,
    input  wire logic       alt_pin_i,
    input  wire logic       alt_own_i,
    input  wire logic [3:0] dir_is_out_i,
    output logic      [4:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // pad follows the latch only while owned and set as output, else pull-down
    assign pad_o[3:0] = unit_pin_i & unit_own_i & dir_is_out_i;
    assign pad_o[4]   = alt_pin_i & alt_own_i & dir_is_out_i[1];
endmodule
